// File: common/cmad_pkg.sv
// Shared constants for the move and arithmetic datapath of the CPU core.
// Assumes one core clock and an active-low asynchronous reset.
package cmad_pkg;

  localparam int unsigned NUM_GPR = 8;
  localparam logic [2:0] SP_IDX = 3'h7;
  localparam logic [31:0] GPR_RST = 32'h0000_0000;

  // Operand sizes.
  localparam logic [1:0] SZ_B = 2'h0;
  localparam logic [1:0] SZ_W = 2'h1;
  localparam logic [1:0] SZ_L = 2'h2;

  // Immediate field lengths.
  localparam logic [1:0] IMM_3 = 2'h0;
  localparam logic [1:0] IMM_8 = 2'h1;
  localparam logic [1:0] IMM_16 = 2'h2;
  localparam logic [1:0] IMM_24 = 2'h3;

  // Step selection for increment, decrement and pointer adjust.
  localparam logic [1:0] STEP_1 = 2'h0;
  localparam logic [1:0] STEP_2 = 2'h1;
  localparam logic [1:0] STEP_4 = 2'h2;

  // Operation codes.
  localparam logic [4:0] OP_XFER = 5'h00;
  localparam logic [4:0] OP_LOAD = 5'h01;
  localparam logic [4:0] OP_STORE = 5'h02;
  localparam logic [4:0] OP_POP = 5'h03;
  localparam logic [4:0] OP_PUSH = 5'h04;
  localparam logic [4:0] OP_ADD = 5'h05;
  localparam logic [4:0] OP_SUB = 5'h06;
  localparam logic [4:0] OP_SUM_WITH_CARRY_OP = 5'h07;
  localparam logic [4:0] OP_DIFFERENCE_WITH_BORROW_OP = 5'h08;
  localparam logic [4:0] OP_INC = 5'h09;
  localparam logic [4:0] OP_DEC = 5'h0a;
  localparam logic [4:0] OP_ADDS = 5'h0b;
  localparam logic [4:0] OP_POINTER_STEP_DOWN = 5'h0c;
  localparam logic [4:0] OP_DAA = 5'h0d;
  localparam logic [4:0] OP_DAS = 5'h0e;
  localparam logic [4:0] OP_MULU = 5'h0f;
  localparam logic [4:0] OP_MULS = 5'h10;
  localparam logic [4:0] OP_PSLOAD = 5'h11;
  localparam logic [4:0] OP_PSSTORE = 5'h12;

  // Condition flag positions and reset value.
  localparam int unsigned FL_C = 0;
  localparam int unsigned FL_V = 1;
  localparam int unsigned FL_Z = 2;
  localparam int unsigned FL_N = 3;
  localparam int unsigned FL_H = 5;
  localparam logic [7:0] CCR_RST = 8'h00;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_MEM = 1'b1
  } cmad_state_t;

endpackage

// File: hdl/cmad_core.sv
// Move and integer arithmetic datapath with general registers and flags.
// Assumes the sequencer decodes opcodes and effective addresses for it.
//
// Operation
// - Eight 32-bit general registers, also reachable as sixteen 16-bit halves.
// - Condition flags hold half-carry, negative, zero, overflow and carry.
// - Immediates come in 3, 8, 16 and 24 bit lengths.
// - Transfer copies B/W/L between registers, memory, or immediate to register.
// - Peripheral-synchronised byte transfers are refused as illegal.
// - Pop loads from stack pointer address, then post-increments it.
// - Push stores register at pre-decremented stack pointer address.
// - Add and subtract B/W/L, register or immediate source, into destination.
// - Subtract of byte immediate is refused.
// - Carry add and borrow subtract are byte only and use carry.
// - Increment and decrement step by one or two.
// - Byte increment and decrement allow a step of one only.
// - Pointer adjust adds or subtracts 1, 2 or 4, longword only.
// - Decimal adjust corrects a byte result to packed BCD using flags.
// - Unsigned multiply gives 8x8 to 16 or 16x16 to 32.
// - Signed multiply gives two's complement 8x8 to 16 or 16x16 to 32.
`timescale 1ns/1ps
module cmad_core import cmad_pkg::*; (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic OP_VALID,
  output logic OP_READY,
  input wire logic [4:0] OP_CODE,
  input wire logic [1:0] OP_SIZE,
  input wire logic [3:0] DST_SEL,
  input wire logic [3:0] SRC_SEL,
  input wire logic USE_IMM,
  input wire logic [23:0] IMM_VALUE,
  input wire logic [1:0] IMM_LEN,
  input wire logic [1:0] STEP_SEL,
  input wire logic [31:0] MEM_EA,
  output logic MEM_REQ,
  output logic MEM_WE,
  output logic [31:0] MEM_ADDR,
  output logic [1:0] MEM_SIZE,
  output logic [31:0] MEM_WDATA,
  input wire logic MEM_ACK,
  input wire logic [31:0] MEM_RDATA,
  output logic OP_DONE,
  output logic OP_ILLEGAL,
  output logic [7:0] COND_FLAGS,
  input wire logic [2:0] DBG_SEL,
  output logic [31:0] DBG_DATA
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rd_get(input logic [31:0] r, input logic [3:0] s,
                                         input logic [1:0] z);
    case (z)
      SZ_B: rd_get = {24'h0, s[3] ? r[7:0] : r[15:8]};
      SZ_W: rd_get = {16'h0, s[3] ? r[31:16] : r[15:0]};
      default: rd_get = r;
    endcase
  endfunction

  function automatic logic [31:0] rd_put(input logic [31:0] r, input logic [3:0] s,
                                         input logic [1:0] z, input logic [31:0] v);
    rd_put = r;
    case (z)
      SZ_B: if (s[3]) rd_put[7:0] = v[7:0]; else rd_put[15:8] = v[7:0];
      SZ_W: if (s[3]) rd_put[31:16] = v[15:0]; else rd_put[15:0] = v[15:0];
      default: rd_put = v;
    endcase
  endfunction

  function automatic logic bit_at(input logic [31:0] v, input logic [1:0] z,
                                  input logic half);
    case (z)
      SZ_B: bit_at = half ? v[4] : v[7];
      SZ_W: bit_at = half ? v[12] : v[15];
      default: bit_at = half ? v[28] : v[31];
    endcase
  endfunction

  function automatic logic [31:0] size_mask(input logic [1:0] z);
    case (z)
      SZ_B: size_mask = 32'h0000_00ff;
      SZ_W: size_mask = 32'h0000_ffff;
      default: size_mask = 32'hffff_ffff;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  cmad_state_t state;
  logic [31:0] gpr [NUM_GPR];
  logic [7:0] condition_flags_reg;
  logic [4:0] pend_op;
  logic [3:0] pend_dst;
  logic [1:0] pend_size;
  logic acc, legal, acc_ok, is_mem, mem_fin;
  logic [31:0] dst_long, src_long, imm_ext, a, b, b_eff, mask, res, wr_val, step_n;
  logic [32:0] raw;
  logic cin, is_sub, cy, hc, a_s, b_s, r_s;
  logic [7:0] next_ccr, dv, dcor, dres;
  logic ccr_en, wr_en, dc;
  logic [31:0] ma, mb, prod;

  assign OP_READY = (state == ST_IDLE);
  assign acc = OP_VALID && OP_READY;
  assign acc_ok = acc && legal;
  assign mem_fin = (state == ST_MEM) && MEM_ACK;
  assign is_mem = (OP_CODE == OP_LOAD) || (OP_CODE == OP_STORE) ||
                  (OP_CODE == OP_POP) || (OP_CODE == OP_PUSH);
  assign dst_long = gpr[DST_SEL[2:0]];
  assign src_long = gpr[SRC_SEL[2:0]];
  assign COND_FLAGS = condition_flags_reg;
  assign DBG_DATA = gpr[DBG_SEL];

  ////////////////////////////////////////////////////////////////////////////
  // Refused forms leave every register and flag untouched.
  always_comb begin
    legal = (OP_SIZE != 2'h3);
    case (OP_CODE)
      OP_XFER, OP_LOAD, OP_STORE, OP_ADD: ;
      OP_PSLOAD, OP_PSSTORE: legal = 1'b0;
      OP_POP, OP_PUSH: legal = legal && (OP_SIZE != SZ_B);
      OP_SUB: legal = legal && !(USE_IMM && OP_SIZE == SZ_B);
      OP_SUM_WITH_CARRY_OP, OP_DIFFERENCE_WITH_BORROW_OP: legal = (OP_SIZE == SZ_B);
      OP_INC, OP_DEC: begin
        legal = legal && (STEP_SEL == STEP_1 || STEP_SEL == STEP_2);
        if (OP_SIZE == SZ_B && STEP_SEL != STEP_1) legal = 1'b0;
      end
      OP_ADDS, OP_POINTER_STEP_DOWN: legal = (OP_SIZE == SZ_L) && (STEP_SEL != 2'h3);
      OP_DAA, OP_DAS: legal = (OP_SIZE == SZ_B);
      OP_MULU, OP_MULS: legal = (OP_SIZE == SZ_B) || (OP_SIZE == SZ_W);
      default: legal = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    case (IMM_LEN)
      IMM_3: imm_ext = {29'h0, IMM_VALUE[2:0]};
      IMM_8: imm_ext = {24'h0, IMM_VALUE[7:0]};
      IMM_16: imm_ext = {16'h0, IMM_VALUE[15:0]};
      default: imm_ext = {8'h0, IMM_VALUE};
    endcase
    case (STEP_SEL)
      STEP_2: step_n = 32'h2;
      STEP_4: step_n = 32'h4;
      default: step_n = 32'h1;
    endcase
  end

  // One shared adder serves add, subtract, carry forms, increment and decrement.
  always_comb begin
    mask = size_mask(OP_SIZE);
    a = rd_get(dst_long, DST_SEL, OP_SIZE);
    b = (USE_IMM ? imm_ext : rd_get(src_long, SRC_SEL, OP_SIZE)) & mask;
    if (OP_CODE == OP_INC || OP_CODE == OP_DEC) b = step_n;
    is_sub = (OP_CODE == OP_SUB) || (OP_CODE == OP_DIFFERENCE_WITH_BORROW_OP) || (OP_CODE == OP_DEC);
    case (OP_CODE)
      OP_SUM_WITH_CARRY_OP: cin = condition_flags_reg[FL_C];
      OP_DIFFERENCE_WITH_BORROW_OP: cin = !condition_flags_reg[FL_C];
      default: cin = is_sub;
    endcase
    b_eff = is_sub ? (~b & mask) : b;
    raw = {1'b0, a} + {1'b0, b_eff} + {32'h0, cin};
    res = raw[31:0] & mask;
    case (OP_SIZE)
      SZ_B: cy = raw[8];
      SZ_W: cy = raw[16];
      default: cy = raw[32];
    endcase
    hc = bit_at(a ^ b_eff ^ res, OP_SIZE, 1'b1);
    a_s = bit_at(a, OP_SIZE, 1'b0);
    b_s = bit_at(b_eff, OP_SIZE, 1'b0);
    r_s = bit_at(res, OP_SIZE, 1'b0);
  end

  // Decimal adjust works on the byte in the destination.
  always_comb begin
    dv = a[7:0];
    dcor = 8'h00;
    dc = condition_flags_reg[FL_C];
    if (OP_CODE == OP_DAA) begin
      if (condition_flags_reg[FL_H] || dv[3:0] > 4'h9) dcor[3:0] = 4'h6;
      if (condition_flags_reg[FL_C] || dv > 8'h99) begin
        dcor[7:4] = 4'h6;
        dc = 1'b1;
      end
      dres = dv + dcor;
    end else begin
      if (condition_flags_reg[FL_H]) dcor[3:0] = 4'h6;
      if (condition_flags_reg[FL_C]) dcor[7:4] = 4'h6;
      dres = dv - dcor;
    end
  end

  // Operands are extended to 32 bits so one product serves all four forms.
  always_comb begin
    if (OP_SIZE == SZ_B) begin
      ma = {24'h0, dst_long[7:0]};
      mb = rd_get(src_long, SRC_SEL, SZ_B);
      if (OP_CODE == OP_MULS) begin
        ma[31:8] = {24{ma[7]}};
        mb[31:8] = {24{mb[7]}};
      end
    end else begin
      ma = {16'h0, dst_long[15:0]};
      mb = rd_get(src_long, SRC_SEL, SZ_W);
      if (OP_CODE == OP_MULS) begin
        ma[31:16] = {16{ma[15]}};
        mb[31:16] = {16{mb[15]}};
      end
    end
    prod = ma * mb;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    wr_en = 1'b1;
    wr_val = dst_long;
    next_ccr = condition_flags_reg;
    ccr_en = 1'b1;
    case (OP_CODE)
      OP_XFER: begin
        wr_val = rd_put(dst_long, DST_SEL, OP_SIZE, b);
        next_ccr[FL_N] = bit_at(b, OP_SIZE, 1'b0);
        next_ccr[FL_Z] = (b == 32'h0);
        next_ccr[FL_V] = 1'b0;
      end
      OP_ADD, OP_SUB, OP_SUM_WITH_CARRY_OP, OP_DIFFERENCE_WITH_BORROW_OP, OP_INC, OP_DEC: begin
        wr_val = rd_put(dst_long, DST_SEL, OP_SIZE, res);
        next_ccr[FL_N] = r_s;
        next_ccr[FL_V] = (a_s == b_s) && (r_s != a_s);
        next_ccr[FL_C] = cy ^ is_sub;
        next_ccr[FL_H] = hc ^ is_sub;
        // Carry forms keep zero only while every chained part is zero.
        if (OP_CODE == OP_SUM_WITH_CARRY_OP || OP_CODE == OP_DIFFERENCE_WITH_BORROW_OP) begin
          next_ccr[FL_Z] = condition_flags_reg[FL_Z] && (res == 32'h0);
        end else begin
          next_ccr[FL_Z] = (res == 32'h0);
        end
      end
      OP_ADDS: begin
        wr_val = dst_long + step_n;
        ccr_en = 1'b0;
      end
      OP_POINTER_STEP_DOWN: begin
        wr_val = dst_long - step_n;
        ccr_en = 1'b0;
      end
      OP_DAA, OP_DAS: begin
        wr_val = rd_put(dst_long, DST_SEL, SZ_B, {24'h0, dres});
        next_ccr[FL_N] = dres[7];
        next_ccr[FL_Z] = (dres == 8'h00);
        next_ccr[FL_V] = 1'b0;
        next_ccr[FL_C] = dc;
      end
      OP_MULU, OP_MULS: begin
        if (OP_SIZE == SZ_B) wr_val = rd_put(dst_long, {1'b0, DST_SEL[2:0]}, SZ_W, prod);
        else wr_val = prod;
        if (OP_CODE == OP_MULS) begin
          next_ccr[FL_N] = (OP_SIZE == SZ_B) ? prod[15] : prod[31];
          next_ccr[FL_Z] = (OP_SIZE == SZ_B) ? (prod[15:0] == 16'h0) : (prod == 32'h0);
        end else begin
          ccr_en = 1'b0;
        end
      end
      default: begin
        wr_en = 1'b0;
        ccr_en = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: if (acc_ok && is_mem) state <= ST_MEM;
        ST_MEM: if (MEM_ACK) state <= ST_IDLE;
      endcase
    end
  end

  // Memory request stands until the acknowledge; store data is caught at accept.
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      MEM_REQ <= 1'b0;
      MEM_WE <= 1'b0;
      MEM_ADDR <= 32'h0;
      MEM_SIZE <= SZ_B;
      MEM_WDATA <= 32'h0;
      pend_op <= OP_XFER;
      pend_dst <= 4'h0;
      pend_size <= SZ_B;
    end else if (acc_ok && is_mem) begin
      MEM_REQ <= 1'b1;
      MEM_WE <= (OP_CODE == OP_STORE) || (OP_CODE == OP_PUSH);
      MEM_SIZE <= OP_SIZE;
      MEM_WDATA <= rd_get(dst_long, DST_SEL, OP_SIZE);
      pend_op <= OP_CODE;
      pend_dst <= DST_SEL;
      pend_size <= OP_SIZE;
      case (OP_CODE)
        OP_POP: MEM_ADDR <= gpr[SP_IDX];
        OP_PUSH: MEM_ADDR <= gpr[SP_IDX] - (OP_SIZE == SZ_L ? 32'h4 : 32'h2);
        default: MEM_ADDR <= MEM_EA;
      endcase
    end else if (mem_fin) begin
      MEM_REQ <= 1'b0;
      MEM_WE <= 1'b0;
    end
  end

  // Later writes win: a pop into the stack pointer keeps the loaded value.
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < NUM_GPR; i++) gpr[i] <= GPR_RST;
    end else begin
      if (acc_ok && !is_mem && wr_en) gpr[DST_SEL[2:0]] <= wr_val;
      if (acc_ok && OP_CODE == OP_PUSH) begin
        gpr[SP_IDX] <= gpr[SP_IDX] - (OP_SIZE == SZ_L ? 32'h4 : 32'h2);
      end
      if (mem_fin && pend_op == OP_POP) begin
        gpr[SP_IDX] <= MEM_ADDR + (pend_size == SZ_L ? 32'h4 : 32'h2);
      end
      if (mem_fin && (pend_op == OP_POP || pend_op == OP_LOAD)) begin
        gpr[pend_dst[2:0]] <= rd_put(gpr[pend_dst[2:0]], pend_dst, pend_size, MEM_RDATA);
      end
    end
  end

  // Transfers of any kind leave negative and zero from the moved value.
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      condition_flags_reg <= CCR_RST;
    end else if (acc_ok && !is_mem && ccr_en) begin
      condition_flags_reg <= next_ccr;
    end else if (acc_ok && is_mem && OP_CODE != OP_LOAD && OP_CODE != OP_POP) begin
      condition_flags_reg[FL_N] <= a_s;
      condition_flags_reg[FL_Z] <= (a == 32'h0);
      condition_flags_reg[FL_V] <= 1'b0;
    end else if (mem_fin && (pend_op == OP_POP || pend_op == OP_LOAD)) begin
      condition_flags_reg[FL_N] <= bit_at(MEM_RDATA, pend_size, 1'b0);
      condition_flags_reg[FL_Z] <= ((MEM_RDATA & size_mask(pend_size)) == 32'h0);
      condition_flags_reg[FL_V] <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      OP_DONE <= 1'b0;
      OP_ILLEGAL <= 1'b0;
    end else begin
      OP_DONE <= (acc_ok && !is_mem) || mem_fin;
      OP_ILLEGAL <= acc && !legal;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  chk_sync_refused: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    acc && (OP_CODE == OP_PSLOAD || OP_CODE == OP_PSSTORE) |=> OP_ILLEGAL && !OP_DONE && !MEM_REQ)
    else $error("peripheral sync transfer was not refused");
  chk_subimm_byte: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    acc && OP_CODE == OP_SUB && USE_IMM && OP_SIZE == SZ_B |=> OP_ILLEGAL && $stable(condition_flags_reg))
    else $error("byte immediate subtract was accepted");
  chk_carry_size: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    acc && (OP_CODE == OP_SUM_WITH_CARRY_OP || OP_CODE == OP_DIFFERENCE_WITH_BORROW_OP) && OP_SIZE != SZ_B |=> OP_ILLEGAL)
    else $error("carry arithmetic accepted a wide size");
  chk_step_byte: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    acc && (OP_CODE == OP_INC || OP_CODE == OP_DEC) && OP_SIZE == SZ_B && STEP_SEL == STEP_2
    |=> OP_ILLEGAL && !OP_DONE)
    else $error("byte step of two was accepted");
  chk_push_addr: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    acc && OP_CODE == OP_PUSH && OP_SIZE == SZ_L
    |=> MEM_REQ && MEM_WE && MEM_ADDR == $past(gpr[SP_IDX]) - 32'h4 && gpr[SP_IDX] == MEM_ADDR)
    else $error("push address is not the pre-decremented stack pointer");
  chk_pop_step: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    mem_fin && pend_op == OP_POP && pend_dst[2:0] != SP_IDX && pend_size == SZ_W
    |=> gpr[SP_IDX] == $past(MEM_ADDR) + 32'h2 && OP_DONE)
    else $error("pop did not post-increment the stack pointer");
  chk_adds_four: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    acc && OP_CODE == OP_ADDS && OP_SIZE == SZ_L && STEP_SEL == STEP_4
    |=> gpr[$past(DST_SEL[2:0])] == $past(dst_long) + 32'h4 && $stable(condition_flags_reg))
    else $error("pointer adjust by four is wrong");
  chk_zero_flag: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    acc && OP_CODE == OP_ADD && OP_SIZE == SZ_L
    |=> COND_FLAGS[FL_Z] == (gpr[$past(DST_SEL[2:0])] == 32'h0))
    else $error("zero flag disagrees with the sum");
  chk_mul_word: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    acc && OP_CODE == OP_MULU && OP_SIZE == SZ_W
    |=> gpr[$past(DST_SEL[2:0])] == {16'h0, $past(dst_long[15:0])} * {16'h0, $past(mb[15:0])})
    else $error("unsigned word product is wrong");

endmodule // cmad_core

// File: dv/cmad_mem_model.sv
// Behavioural memory that answers the datapath's load, store, push and pop cycles.
// Assumes one request at a time, held steady by the datapath until acknowledged.
`timescale 1ns/1ps
module cmad_mem_model import cmad_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] lat,
  input wire logic req,
  input wire logic we,
  input wire logic [31:0] addr,
  input wire logic [1:0] size,
  input wire logic [31:0] wdata,
  output logic ack,
  output logic [31:0] rdata
);
  logic [31:0] mem [logic [31:0]];
  logic [1:0] cnt;
  logic [31:0] msk;

  ////////////////////////////////////////////////////////////////////////////////
  assign msk = (size == SZ_B) ? 32'hff : ((size == SZ_W) ? 32'hffff : 32'hffffffff);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
      cnt <= 2'h0;
      rdata <= 32'h0;
    end else begin
      ack <= 1'b0;
      // The data bus toggles when idle so a stale word never passes for a fresh one.
      rdata <= ~rdata;
      if (req && !ack) begin
        if (cnt >= lat) begin
          ack <= 1'b1;
          cnt <= 2'h0;
          if (we) mem[addr] = wdata;
          else rdata <= (mem.exists(addr) ? mem[addr] : 32'h0) & msk;
        end else cnt <= cnt + 2'h1;
      end
    end
  end
endmodule // cmad_mem_model

// File: dv/testbench.sv
// Self-checking bench for the move and arithmetic datapath.
// Assumes the memory model in dv/ and the shared package in common/.
`timescale 1ns/1ps
module testbench import cmad_pkg::*;;
  logic clk, rst_n, op_valid, op_ready, use_imm, mem_req, mem_we, mem_ack, op_done, op_ill;
  logic [4:0] op_code;
  logic [1:0] op_size, imm_len, step_sel, mem_size, lat, wr_size;
  logic [3:0] dst_sel, src_sel;
  logic [23:0] imm_value;
  logic [31:0] mem_ea, mem_addr, mem_wdata, mem_rdata, dbg_data, wr_addr, wr_data, a, b;
  logic [7:0] flags, f0;
  logic [2:0] dbg_sel;
  logic s;
  int n_errors, cmp_count, ready_bad;

  ////////////////////////////////////////////////////////////////////////////////
  cmad_core cmad_core_inst (.CORE_CLK(clk), .RST_N(rst_n), .OP_VALID(op_valid),
    .OP_READY(op_ready), .OP_CODE(op_code), .OP_SIZE(op_size), .DST_SEL(dst_sel),
    .SRC_SEL(src_sel), .USE_IMM(use_imm), .IMM_VALUE(imm_value), .IMM_LEN(imm_len),
    .STEP_SEL(step_sel), .MEM_EA(mem_ea), .MEM_REQ(mem_req), .MEM_WE(mem_we),
    .MEM_ADDR(mem_addr), .MEM_SIZE(mem_size), .MEM_WDATA(mem_wdata), .MEM_ACK(mem_ack),
    .MEM_RDATA(mem_rdata), .OP_DONE(op_done), .OP_ILLEGAL(op_ill), .COND_FLAGS(flags),
    .DBG_SEL(dbg_sel), .DBG_DATA(dbg_data));
  cmad_mem_model cmad_mem_model_inst (.clk(clk), .rst_n(rst_n), .lat(lat), .req(mem_req),
    .we(mem_we), .addr(mem_addr), .size(mem_size), .wdata(mem_wdata), .ack(mem_ack),
    .rdata(mem_rdata));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // The request is held until ready is seen high after an edge, then the answer is awaited.
  task automatic op(input logic [4:0] c, input logic [1:0] sz, input logic [3:0] d, sr,
      input logic ui, input logic [23:0] iv, input logic [1:0] il, st, input logic ill);
    int n;
    n = 0;
    @(posedge clk);
    op_valid <= 1'b1;
    op_code <= c;
    op_size <= sz;
    dst_sel <= d;
    src_sel <= sr;
    use_imm <= ui;
    imm_value <= iv;
    imm_len <= il;
    step_sel <= st;
    @(posedge clk);
    while (op_ready !== 1'b1) @(posedge clk);
    op_valid <= 1'b0;
    #1;
    while (op_done !== 1'b1 && op_ill !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("answer", {30'h0, ill, ~ill}, {30'h0, op_ill, op_done});
  endtask

  task automatic q(input logic [4:0] c, input logic [1:0] sz, input logic [3:0] d, sr,
      input logic ill);
    op(c, sz, d, sr, 1'b0, 24'h0, IMM_8, STEP_1, ill);
  endtask

  task automatic qi(input logic [4:0] c, input logic [1:0] sz, input logic [3:0] d,
      input logic [23:0] iv, input logic ill);
    op(c, sz, d, 4'h0, 1'b1, iv, IMM_24, STEP_1, ill);
  endtask

  task automatic qs(input logic [4:0] c, input logic [1:0] sz, input logic [3:0] d,
      input logic [1:0] st, input logic ill);
    op(c, sz, d, 4'h0, 1'b0, 24'h0, IMM_8, st, ill);
  endtask

  task automatic set_reg(input logic [2:0] i, input logic [31:0] x);
    qi(OP_XFER, SZ_L, {1'b0, i}, x[23:0], 1'b0);
    qi(OP_XFER, SZ_W, {1'b1, i}, {8'h0, x[31:16]}, 1'b0);
  endtask

  task automatic ckr(input logic [2:0] i, input logic [31:0] e);
    @(posedge clk);
    dbg_sel <= i;
    #1;
    chk($sformatf("reg%0d", i), e, dbg_data);
  endtask

  function automatic logic [3:0] nzvc(input logic [31:0] x, y, input logic sub);
    logic [32:0] r;
    logic [31:0] yy;
    yy = sub ? ~y : y;
    r = {1'b0, x} + {1'b0, yy} + {32'h0, sub};
    return {r[31], r[31:0] == 32'h0, (x[31] == yy[31]) && (r[31] != x[31]), r[32] ^ sub};
  endfunction

  function automatic logic [31:0] mulx(input logic [31:0] x, y, input logic w, sg);
    logic [31:0] m, n;
    m = w ? {{16{sg & x[15]}}, x[15:0]} : {{24{sg & x[7]}}, x[7:0]};
    n = w ? {{16{sg & y[15]}}, y[15:0]} : {{24{sg & y[7]}}, y[7:0]};
    return w ? m * n : {x[31:16], 16'(m * n)};
  endfunction

  // A pending memory cycle must hold off new operations.
  always @(posedge clk) begin
    if (mem_req && op_ready !== 1'b0) ready_bad <= ready_bad + 1;
    if (mem_req && mem_ack && mem_we) begin
      wr_addr <= mem_addr;
      wr_data <= mem_wdata;
      wr_size <= mem_size;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("watchdog expired");
    give_verdict();
  end

  initial begin
    {rst_n, op_valid, use_imm, s} = 4'h0;
    {op_code, op_size, imm_len, step_sel, lat, dst_sel, src_sel, dbg_sel} = 24'h0;
    {imm_value, mem_ea} = 56'h0;
    n_errors = 0;
    ready_bad = 0;
    cmp_count = 0;
    void'($urandom(95));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) ckr(3'(i), GPR_RST);
    chk("flags", {24'h0, CCR_RST}, {24'h0, flags});
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
      op(OP_XFER, SZ_L, 4'h1, 4'h0, 1'b1, 24'hfedcba, 2'(k), STEP_1, 1'b0);
      ckr(3'h1, ((32'h1 << (k == 0 ? 3 : 8 * k)) - 32'h1) & 32'hfedcba);
    end
    set_reg(3'h1, 32'hdead3456);
    ckr(3'h1, 32'hdead3456);
    q(OP_XFER, SZ_B, 4'h2, 4'h9, 1'b0);
    ckr(3'h2, 32'h5600);
    $display("test transfer done");
    set_reg(3'h7, 32'h1000);
    lat <= 2'($urandom_range(3));
    q(OP_PUSH, SZ_L, 4'h1, 4'h0, 1'b0);
    chk("push address", 32'hffc, wr_addr);
    chk("push data", 32'hdead3456, wr_data);
    chk("push size", {30'h0, SZ_L}, {30'h0, wr_size});
    ckr(3'h7, 32'hffc);
    lat <= 2'($urandom_range(3));
    q(OP_POP, SZ_W, 4'h2, 4'h0, 1'b0);
    ckr(3'h2, 32'h3456);
    ckr(3'h7, 32'hffe);
    q(OP_PUSH, SZ_B, 4'h1, 4'h0, 1'b1);
    mem_ea <= 32'h2000;
    q(OP_STORE, SZ_L, 4'h1, 4'h0, 1'b0);
    chk("store data", 32'hdead3456, wr_data);
    q(OP_LOAD, SZ_B, 4'hb, 4'h0, 1'b0);
    ckr(3'h3, 32'h56);
    chk("ready while busy", 32'h0, ready_bad);
    $display("test stack and memory done");
    for (int k = 0; k < 12; k++) begin
      a = (k == 0) ? 32'h7fffffff : ((k == 1) ? 32'h0 : $urandom);
      b = (k < 2) ? 32'h1 : $urandom;
      s = (k == 1) ? 1'b1 : ((k == 0) ? 1'b0 : 1'($urandom_range(1)));
      set_reg(3'h4, a);
      set_reg(3'h5, b);
      q(s ? OP_SUB : OP_ADD, SZ_L, 4'h4, 4'h5, 1'b0);
      ckr(3'h4, s ? a - b : a + b);
      chk("nzvc", {28'h0, nzvc(a, b, s)}, {28'h0, flags[3:0]});
    end
    $display("test add and subtract done");
    set_reg(3'h6, 32'hff);
    qi(OP_ADD, SZ_B, 4'he, 24'h1, 1'b0);
    chk("nzvc", 32'h5, {28'h0, flags[3:0]});
    qi(OP_SUM_WITH_CARRY_OP, SZ_B, 4'he, 24'h5, 1'b0);
    ckr(3'h6, 32'h6);
    qi(OP_DIFFERENCE_WITH_BORROW_OP, SZ_B, 4'he, 24'h7, 1'b0);
    ckr(3'h6, 32'hff);
    chk("nzvc", 32'h9, {28'h0, flags[3:0]});
    f0 = flags;
    q(OP_PSLOAD, SZ_B, 4'he, 4'h0, 1'b1);
    q(OP_PSSTORE, SZ_B, 4'he, 4'h0, 1'b1);
    qi(OP_SUB, SZ_B, 4'he, 24'h1, 1'b1);
    q(OP_SUM_WITH_CARRY_OP, SZ_W, 4'h6, 4'h0, 1'b1);
    q(OP_DIFFERENCE_WITH_BORROW_OP, SZ_L, 4'h6, 4'h0, 1'b1);
    qs(OP_INC, SZ_B, 4'he, STEP_2, 1'b1);
    qs(OP_DEC, SZ_W, 4'h6, STEP_4, 1'b1);
    qs(OP_ADDS, SZ_W, 4'h6, STEP_1, 1'b1);
    qs(OP_POINTER_STEP_DOWN, SZ_L, 4'h6, 2'h3, 1'b1);
    q(OP_DAA, SZ_W, 4'h6, 4'h0, 1'b1);
    q(OP_MULU, SZ_L, 4'h6, 4'h0, 1'b1);
    q(OP_MULS, SZ_L, 4'h6, 4'h0, 1'b1);
    ckr(3'h6, 32'hff);
    chk("flags kept", {24'h0, f0}, {24'h0, flags});
    $display("test carry and refusal done");
    set_reg(3'h0, 32'h7fffffff);
    qs(OP_INC, SZ_L, 4'h0, STEP_1, 1'b0);
    ckr(3'h0, 32'h80000000);
    chk("nzvc", 32'ha, {28'h0, flags[3:0]});
    qs(OP_DEC, SZ_L, 4'h0, STEP_2, 1'b0);
    ckr(3'h0, 32'h7ffffffe);
    chk("nzvc", 32'h2, {28'h0, flags[3:0]});
    qs(OP_INC, SZ_W, 4'h0, STEP_2, 1'b0);
    qs(OP_INC, SZ_B, 4'h8, STEP_1, 1'b0);
    ckr(3'h0, 32'h7fff0001);
    f0 = flags;
    for (int k = 0; k < 3; k++) qs(OP_ADDS, SZ_L, 4'h0, 2'(k), 1'b0);
    qs(OP_POINTER_STEP_DOWN, SZ_L, 4'h0, STEP_4, 1'b0);
    ckr(3'h0, 32'h7fff0004);
    chk("flags kept", {24'h0, f0}, {24'h0, flags});
    $display("test step done");
    set_reg(3'h3, 32'h9);
    qi(OP_ADD, SZ_B, 4'hb, 24'h8, 1'b0);
    q(OP_DAA, SZ_B, 4'hb, 4'h0, 1'b0);
    ckr(3'h3, 32'h17);
    set_reg(3'h3, 32'h10);
    set_reg(3'h5, 32'h1);
    q(OP_SUB, SZ_B, 4'hb, 4'hd, 1'b0);
    q(OP_DAS, SZ_B, 4'hb, 4'h0, 1'b0);
    ckr(3'h3, 32'h9);
    $display("test decimal done");
    for (int k = 0; k < 8; k++) begin
      a = $urandom;
      b = $urandom;
      set_reg(3'h4, a);
      set_reg(3'h5, b);
      q(k[1] ? OP_MULS : OP_MULU, k[0] ? SZ_W : SZ_B, k[0] ? 4'h4 : 4'hc,
        k[0] ? 4'h5 : 4'hd, 1'b0);
      ckr(3'h4, mulx(a, b, k[0], k[1]));
    end
    $display("test multiply done");
    give_verdict();
  end
endmodule // testbench
